// >>> rtl/instr_exec_pkg.sv
package instr_exec_pkg;

    // Widths
    localparam int DATA_W  = 8;
    localparam int ADDR_W  = 7;
    localparam int INSTR_W = 14;
    localparam int PADDR_W = 12;

    // Instruction field positions
    localparam int GRP4_LSB = 10;
    localparam int GRP6_LSB = 8;
    localparam int BIT_MSB  = 9;
    localparam int BIT_LSB  = 7;
    localparam int F_MSB    = 6;
    localparam int DEST_POS = 7;
    localparam int K_MSB    = 7;

    // Opcode groups
    localparam logic [3:0] OPC_BIT_CLR   = 4'h4;
    localparam logic [3:0] OPC_BIT_SET   = 4'h5;
    localparam logic [3:0] OPC_SKIP_LOW  = 4'h6;
    localparam logic [3:0] OPC_SKIP_HIGH = 4'h7;
    localparam logic [5:0] OPC_REG_ADD   = 6'h07;
    localparam logic [5:0] OPC_REG_AND   = 6'h05;
    localparam logic [5:0] OPC_LIT_AND   = 6'h39;

    // Destination select values
    localparam logic DEST_ACC  = 1'b0;
    localparam logic DEST_FILE = 1'b1;

    // Register file locations of the pin port and its direction latch, and the reset values of the file
    localparam logic [ADDR_W-1:0] PORT_ADDR = 7'h06;
    localparam logic [ADDR_W-1:0] DIR_ADDR  = 7'h07;
    localparam logic [DATA_W-1:0] DIR_RESET = 8'hFF;
    localparam logic [DATA_W-1:0] FILE_RESET = 8'h00;

    // Bus map, byte addresses
    localparam logic [PADDR_W-1:0] OFS_CTRL      = 12'h000;
    localparam logic [PADDR_W-1:0] OFS_ACC       = 12'h004;
    localparam logic [PADDR_W-1:0] OFS_FLAGS     = 12'h008;
    localparam logic [PADDR_W-1:0] OFS_FILE_BASE = 12'h200;

    // Field positions in the control and flag words
    localparam int CTRL_RUN  = 0;
    localparam int FLAG_C    = 0;
    localparam int FLAG_NIBBLE = 1;
    localparam int FLAG_Z    = 2;
    localparam int FLAG_SKIP = 3;

    // Operations of the arithmetic unit
    typedef enum logic [2:0] {
        alu_pass,
        alu_add,
        alu_and,
        alu_clr,
        alu_set
    } alu_op_e;

endpackage : instr_exec_pkg

// >>> rtl/alu_if.sv
interface alu_if;
    logic [7:0]              lhs;
    logic [7:0]              rhs;
    logic [2:0]              bit_sel;
    instr_exec_pkg::alu_op_e op;
    logic [7:0]              result;
    logic                    carry;
    logic                    nibble_overflow_bit;
    logic                    zero;
    logic                    bit_value;

    modport client (output lhs, rhs, bit_sel, op, input result, carry, nibble_overflow_bit, zero, bit_value);
    modport unit   (input lhs, rhs, bit_sel, op, output result, carry, nibble_overflow_bit, zero, bit_value);
endinterface : alu_if

// >>> rtl/bit_logic_alu.sv
module bit_logic_alu (
    // Operands and results
    alu_if.unit u
);

    logic [8:0] full_sum;
    logic [4:0] low_sum;
    logic [7:0] bit_mask;

    // Wide sums keep the carries out of bit 7 and bit 3
    assign full_sum = {1'b0, u.lhs} + {1'b0, u.rhs};
    assign low_sum  = {1'b0, u.lhs[3:0]} + {1'b0, u.rhs[3:0]};
    assign bit_mask = 8'h01 << u.bit_sel;

    // Result select
    always_comb begin
        case (u.op)
            instr_exec_pkg::alu_add: u.result = full_sum[7:0];
            instr_exec_pkg::alu_and: u.result = u.lhs & u.rhs;
            instr_exec_pkg::alu_clr: u.result = u.rhs & ~bit_mask;
            instr_exec_pkg::alu_set: u.result = u.rhs | bit_mask;
            default:                 u.result = u.rhs;
        endcase
    end

    // Flag candidates; the caller decides which ones land
    assign u.carry               = full_sum[8];
    assign u.nibble_overflow_bit = low_sum[4];
    assign u.zero                = (u.result == 8'h00);
    assign u.bit_value           = u.rhs[u.bit_sel];

endmodule : bit_logic_alu

// >>> rtl/bit_and_logic_instr_exec.sv
module bit_and_logic_instr_exec #(
    parameter int FILE_DEPTH = 128,
    parameter int PORT_WIDTH = 4
) (
    // Clock and reset
    input  wire logic                   clock,
    input  wire logic                   rstn,
    // APB slave
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [11:0]            paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    // Instruction stream from fetch
    input  wire logic                   instr_valid,
    input  wire logic [13:0]            instr,
    // Core state
    output logic      [7:0]             acc,
    output logic                        carry,
    output logic                        nibble_overflow_bit,
    output logic                        zero,
    output logic                        skip_pending,
    output logic                        instr_discarded,
    // Pins
    input  wire logic [PORT_WIDTH-1:0]  port_in,
    output logic      [PORT_WIDTH-1:0]  port_out,
    output logic      [PORT_WIDTH-1:0]  port_oe_n
);

    localparam int DW = instr_exec_pkg::DATA_W;
    localparam int AW = instr_exec_pkg::ADDR_W;

    // Elaboration checks
    if (FILE_DEPTH > (1 << AW) || FILE_DEPTH <= int'(instr_exec_pkg::DIR_ADDR)) begin : g_bad_depth
        $error("FILE_DEPTH must hold the port and direction registers and fit 7 address bits");
    end
    if (PORT_WIDTH < 1 || PORT_WIDTH > DW) begin : g_bad_width
        $error("PORT_WIDTH must be 1 to 8");
    end

    logic [DW-1:0]         file_mem [FILE_DEPTH];
    logic [PORT_WIDTH-1:0] port_meta;
    logic [PORT_WIDTH-1:0] port_sync;
    logic                  run;

    alu_if alu_bus ();

    bit_logic_alu u_alu (
        .u (alu_bus.unit)
    );

    // Instruction fields
    wire [3:0]    grp4     = instr[instr_exec_pkg::INSTR_W-1:instr_exec_pkg::GRP4_LSB];
    wire [5:0]    grp6     = instr[instr_exec_pkg::INSTR_W-1:instr_exec_pkg::GRP6_LSB];
    wire [AW-1:0] f_addr   = instr[instr_exec_pkg::F_MSB:0];
    wire [2:0]    bit_sel  = instr[instr_exec_pkg::BIT_MSB:instr_exec_pkg::BIT_LSB];
    wire          dest     = instr[instr_exec_pkg::DEST_POS];
    wire [DW-1:0] literal  = instr[instr_exec_pkg::K_MSB:0];

    // Opcode decode
    wire is_clr       = (grp4 == instr_exec_pkg::OPC_BIT_CLR);
    wire is_set       = (grp4 == instr_exec_pkg::OPC_BIT_SET);
    wire is_skip_low  = (grp4 == instr_exec_pkg::OPC_SKIP_LOW);
    wire is_skip_high = (grp4 == instr_exec_pkg::OPC_SKIP_HIGH);
    wire is_add       = (grp6 == instr_exec_pkg::OPC_REG_ADD);
    wire is_and       = (grp6 == instr_exec_pkg::OPC_REG_AND);
    wire is_lit_and   = (grp6 == instr_exec_pkg::OPC_LIT_AND);

    // Issue control: a slot after a taken skip is spent as a NOP
    wire issue   = instr_valid & run;
    wire exec_ok = issue & ~skip_pending;
    wire discard = issue & skip_pending;

    // Operand fetch; unimplemented addresses read as zero
    wire          f_in_range = (32'(f_addr) < FILE_DEPTH);
    wire [DW-1:0] file_rd    = f_in_range ? file_mem[f_addr] : '0;
    wire [DW-1:0] pin_view   = DW'(port_sync);
    wire [DW-1:0] operand    = (f_addr == instr_exec_pkg::PORT_ADDR) ? pin_view : file_rd;

    // Arithmetic unit drive
    assign alu_bus.lhs     = acc;
    assign alu_bus.rhs     = is_lit_and ? literal : operand;
    assign alu_bus.bit_sel = bit_sel;
    assign alu_bus.op      = is_clr ? instr_exec_pkg::alu_clr :
                             is_set ? instr_exec_pkg::alu_set :
                             is_add ? instr_exec_pkg::alu_add :
                             (is_and | is_lit_and) ? instr_exec_pkg::alu_and :
                             instr_exec_pkg::alu_pass;

    // Destination steering
    wire reg_op     = is_add | is_and;
    wire exec_file  = exec_ok & f_in_range & (is_clr | is_set | (reg_op & dest == instr_exec_pkg::DEST_FILE));
    wire exec_acc   = exec_ok & (is_lit_and | (reg_op & dest == instr_exec_pkg::DEST_ACC));
    wire exec_cdc   = exec_ok & is_add;
    wire exec_zero  = exec_ok & (is_add | is_and | is_lit_and);
    wire take_skip  = exec_ok & ((is_skip_low & ~alu_bus.bit_value) | (is_skip_high & alu_bus.bit_value));

    // Bus decode
    wire          apb_access = psel & penable;
    wire          apb_done   = apb_access & pready;
    wire          aligned    = (paddr[1:0] == 2'b00);
    wire [AW-1:0] apb_idx    = paddr[AW+1:2];
    wire          hit_ctrl   = aligned & (paddr == instr_exec_pkg::OFS_CTRL);
    wire          hit_acc    = aligned & (paddr == instr_exec_pkg::OFS_ACC);
    wire          hit_flags  = aligned & (paddr == instr_exec_pkg::OFS_FLAGS);
    wire          hit_file   = aligned & (paddr >= instr_exec_pkg::OFS_FILE_BASE) &
                               (32'(paddr - instr_exec_pkg::OFS_FILE_BASE) < 4 * FILE_DEPTH);
    wire          mapped     = hit_ctrl | hit_acc | hit_flags | hit_file;
    // Core state is open to software writes only while halted, so no two writers race
    wire          apb_bad    = ~mapped | (pwrite & run & ~hit_ctrl);
    wire          apb_we     = apb_done & pwrite & ~apb_bad;

    // Read data select
    wire [31:0] flags_word = 32'({skip_pending, zero, nibble_overflow_bit, carry});
    wire [31:0] read_word  = hit_ctrl  ? 32'(run) :
                             hit_acc   ? 32'(acc) :
                             hit_flags ? flags_word :
                             hit_file  ? 32'(file_mem[apb_idx]) : 32'h0000_0000;

    // Pin synchroniser, two stages before any reader
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            port_meta <= '0;
            port_sync <= '0;
        end else begin
            port_meta <= port_in;
            port_sync <= port_meta;
        end
    end

    // Register file, one process per entry
    for (genvar i = 0; i < FILE_DEPTH; i++) begin : g_file
        localparam logic [DW-1:0] RST_VAL = (i == int'(instr_exec_pkg::DIR_ADDR)) ?
                                            instr_exec_pkg::DIR_RESET : instr_exec_pkg::FILE_RESET;
        wire exec_hit = exec_file & (f_addr == AW'(i));
        wire apb_hit  = apb_we & hit_file & (apb_idx == AW'(i));
        always_ff @(posedge clock or negedge rstn) begin
            if (!rstn) begin
                file_mem[i] <= RST_VAL;
            end else if (exec_hit) begin
                file_mem[i] <= alu_bus.result;
            end else if (apb_hit) begin
                file_mem[i] <= pwdata[DW-1:0];
            end
        end
    end

    // Pin drive mirrors the latch; a direction bit of 1 leaves the pin undriven
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            port_out  <= '0;
            port_oe_n <= '1;
        end else begin
            port_out  <= file_mem[instr_exec_pkg::PORT_ADDR][PORT_WIDTH-1:0];
            port_oe_n <= file_mem[instr_exec_pkg::DIR_ADDR][PORT_WIDTH-1:0];
        end
    end

    // Accumulator
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            acc <= '0;
        end else if (exec_acc) begin
            acc <= alu_bus.result;
        end else if (apb_we & hit_acc) begin
            acc <= pwdata[DW-1:0];
        end
    end

    // Carry and nibble carry move only on add or on a bus write to the flag word
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            carry               <= 1'b0;
            nibble_overflow_bit <= 1'b0;
        end else if (exec_cdc) begin
            carry               <= alu_bus.carry;
            nibble_overflow_bit <= alu_bus.nibble_overflow_bit;
        end else if (apb_we & hit_flags) begin
            carry               <= pwdata[instr_exec_pkg::FLAG_C];
            nibble_overflow_bit <= pwdata[instr_exec_pkg::FLAG_NIBBLE];
        end
    end

    // Zero flag; bit ops and tests never reach here
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            zero <= 1'b0;
        end else if (exec_zero) begin
            zero <= alu_bus.zero;
        end else if (apb_we & hit_flags) begin
            zero <= pwdata[instr_exec_pkg::FLAG_Z];
        end
    end

    // Skip bookkeeping: the test costs one slot, the discarded one a second
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            skip_pending    <= 1'b0;
            instr_discarded <= 1'b0;
        end else begin
            if (skip_pending) begin
                skip_pending <= ~discard;
            end else begin
                skip_pending <= take_skip;
            end
            instr_discarded <= discard;
        end
    end

    // Run control, writable at any time
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            run <= 1'b0;
        end else if (apb_we & hit_ctrl) begin
            run <= pwdata[instr_exec_pkg::CTRL_RUN];
        end
    end

    // Bus answer: one wait state, data and error captured with ready
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= apb_access & ~pready;
            pslverr <= apb_access & ~pready & apb_bad;
            if (apb_access & ~pready) begin
                prdata <= pwrite ? 32'h0000_0000 : read_word;
            end
        end
    end

endmodule : bit_and_logic_instr_exec

// >>> verification/bit_and_logic_instr_exec_props.sv
module bit_and_logic_instr_exec_props (
    // Clock and reset
    input wire logic        clock,
    input wire logic        rstn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Instructions and core state
    input wire logic        instr_valid,
    input wire logic [13:0] instr,
    input wire logic [7:0]  acc,
    input wire logic        carry,
    input wire logic        nibble_overflow_bit,
    input wire logic        zero,
    input wire logic        skip_pending,
    input wire logic        instr_discarded
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    // Shadow of the run bit, since it is not a port
    logic run;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) run <= 1'b0;
        else if (psel && penable && pready && pwrite && paddr == instr_exec_pkg::OFS_CTRL) run <= pwdata[0];
    end
    wire       exec_ok = instr_valid && run && !skip_pending;
    wire [5:0] grp6    = instr[13:8];
    wire       reg_op  = grp6 == instr_exec_pkg::OPC_REG_ADD || grp6 == instr_exec_pkg::OPC_REG_AND;

    property p_wait; psel && !penable |=> !pready ##1 pready ##1 !pready; endproperty
    a_wait: assert property (p_wait) else $error("APB wait state wrong");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("Error flag without ready");
    property p_disc; instr_valid && run && skip_pending |=> instr_discarded && !skip_pending && $stable(acc); endproperty
    a_disc: assert property (p_disc) else $error("Slot after skip not discarded");
    property p_pulse; instr_discarded |=> !instr_discarded; endproperty
    a_pulse: assert property (p_pulse) else $error("Discard pulse too long");
    property p_bitops; exec_ok && instr[13:12] == 2'b01 |=> $stable({acc, carry, nibble_overflow_bit, zero}); endproperty
    a_bitops: assert property (p_bitops) else $error("Bit op touched acc or flags");
    property p_lit;
        exec_ok && grp6 == instr_exec_pkg::OPC_LIT_AND |=> acc == ($past(acc) & $past(instr[7:0]))
            && zero == (acc == 8'h00) && $stable(carry) && $stable(nibble_overflow_bit);
    endproperty
    a_lit: assert property (p_lit) else $error("Literal and wrong");
    property p_add; exec_ok && grp6 == instr_exec_pkg::OPC_REG_ADD && !instr[7] |=> zero == (acc == 8'h00); endproperty
    a_add: assert property (p_add) else $error("Add zero flag wrong");
    property p_and; exec_ok && grp6 == instr_exec_pkg::OPC_REG_AND |=> $stable({carry, nibble_overflow_bit}); endproperty
    a_and: assert property (p_and) else $error("Register and changed carry");
    property p_dest; exec_ok && reg_op && instr[7] |=> $stable(acc); endproperty
    a_dest: assert property (p_dest) else $error("File destination changed acc");

    // Main scenarios reached
    c_disc: cover property (instr_discarded);
    c_lit: cover property (exec_ok && grp6 == instr_exec_pkg::OPC_LIT_AND);
    c_err: cover property (pslverr);
endmodule : bit_and_logic_instr_exec_props

bind bit_and_logic_instr_exec bit_and_logic_instr_exec_props u_bit_and_logic_instr_exec_props (.*);

// >>> verification/bit_and_logic_instr_exec_tb_top.sv
module bit_and_logic_instr_exec_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, instr_valid = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r, r2;
    logic [13:0] instr = 14'h0000, op_i;
    logic [3:0]  port_in = 4'h0, port_out, port_oe_n, pin;
    logic [7:0]  acc, ea, ef;
    logic [6:0]  f;
    logic        pready, pslverr, carry, nibble_overflow_bit, zero, skip_pending, instr_discarded;
    logic        ec, edc, ez, skip;
    logic [9:0]  sum;
    int          err_total = 0, total_checks = 0, seed = 32'h09AF;

    bit_and_logic_instr_exec u_bit_and_logic_instr_exec (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .instr_valid(instr_valid), .instr(instr), .acc(acc), .carry(carry), .nibble_overflow_bit(nibble_overflow_bit),
        .zero(zero), .skip_pending(skip_pending), .instr_discarded(instr_discarded), .port_in(port_in),
        .port_out(port_out), .port_oe_n(port_oe_n));

    // Clock and a two-cycle reset
    always #5 clock = ~clock;
    initial begin
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer; read data checked only on reads
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [31:0] e, input logic er);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        chk(pslverr, er);
        if (!wr) chk(prdata, e);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    function automatic logic [11:0] fa(input logic [6:0] a);
        return instr_exec_pkg::OFS_FILE_BASE + {3'h0, a, 2'b00};
    endfunction : fa

    // Expected add: {nibble carry, carry, byte sum}, nine bits kept so the carry survives
    function automatic logic [9:0] add_exp(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] s;
        logic [4:0] nb;
        s = {1'b0, a} + {1'b0, b};
        nb = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        return {nb[4], s};
    endfunction : add_exp

    // Two instructions in consecutive slots
    task automatic ex2(input logic [13:0] i1, input logic [13:0] i2, input logic s);
        @(posedge clock);
        instr_valid <= 1'b1;
        instr <= i1;
        @(posedge clock);
        instr <= i2;
        @(posedge clock);
        chk(skip_pending, s);
        instr_valid <= 1'b0;
    endtask : ex2

    task automatic stop_test;
        $display("Checks %0d, errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : stop_test

    // Watchdog sized well above the expected run
    initial begin
        repeat (30000) @(posedge clock);
        err_total++;
        stop_test;
    end

    initial begin
        @(posedge rstn);
        xfer(1'b0, instr_exec_pkg::OFS_FLAGS, 0, 0, 1'b0);
        xfer(1'b0, fa(7'h07), 0, 32'h0000_00FF, 1'b0);
        xfer(1'b0, 12'h100, 0, 0, 1'b1);
        xfer(1'b1, 12'h002, 0, 0, 1'b1);
        chk(port_oe_n, 32'h0000_000F);
        // Random operands, every operation in turn, follower in the next slot
        for (int n = 0; n < 70; n++) begin
            r = $random(seed);
            r2 = $random(seed);
            // Corner: both carries out and a zero sum on the first add
            if (n == 4) r[15:0] = 16'h01FF;
            f = 7'h10 + {1'b0, r2[5:0]};
            ea = r[7:0];
            ef = r[15:8];
            {ez, edc, ec} = r[30:28];
            skip = 1'b0;
            case (n % 7)
                0: begin
                    op_i = {instr_exec_pkg::OPC_BIT_CLR, r[26:24], f};
                    ef[r[26:24]] = 1'b0;
                end
                1: begin
                    op_i = {instr_exec_pkg::OPC_BIT_SET, r[26:24], f};
                    ef[r[26:24]] = 1'b1;
                end
                2: begin
                    op_i = {instr_exec_pkg::OPC_SKIP_LOW, r[26:24], f};
                    skip = !ef[r[26:24]];
                end
                3: begin
                    op_i = {instr_exec_pkg::OPC_SKIP_HIGH, r[26:24], f};
                    skip = ef[r[26:24]];
                end
                4: begin
                    op_i = {instr_exec_pkg::OPC_REG_ADD, r[27], f};
                    sum = add_exp(ea, ef);
                    {edc, ec} = sum[9:8];
                    if (r[27]) ef = sum[7:0];
                    else ea = sum[7:0];
                    ez = (r[27] ? ef : ea) == 8'h00;
                end
                5: begin
                    op_i = {instr_exec_pkg::OPC_REG_AND, r[27], f};
                    if (r[27]) ef = ea & ef;
                    else ea = ea & ef;
                    ez = (r[27] ? ef : ea) == 8'h00;
                end
                default: begin
                    op_i = {instr_exec_pkg::OPC_LIT_AND, r[23:16]};
                    ea = ea & r[23:16];
                    ez = ea == 8'h00;
                end
            endcase
            if (!skip) ea = ea & r2[15:8];
            if (!skip) ez = ea == 8'h00;
            xfer(1'b1, instr_exec_pkg::OFS_ACC, r[7:0], 0, 1'b0);
            xfer(1'b1, instr_exec_pkg::OFS_FLAGS, r[30:28], 0, 1'b0);
            xfer(1'b1, fa(f), r[15:8], 0, 1'b0);
            xfer(1'b1, instr_exec_pkg::OFS_CTRL, 1, 0, 1'b0);
            xfer(1'b1, instr_exec_pkg::OFS_ACC, 32'h55, 0, 1'b1);
            ex2(op_i, {instr_exec_pkg::OPC_LIT_AND, r2[15:8]}, skip);
            @(posedge clock);
            chk(instr_discarded, skip);
            chk({acc, zero, nibble_overflow_bit, carry}, {ea, ez, edc, ec});
            xfer(1'b1, instr_exec_pkg::OFS_CTRL, 0, 0, 1'b0);
            xfer(1'b0, instr_exec_pkg::OFS_ACC, 0, ea, 1'b0);
            xfer(1'b0, instr_exec_pkg::OFS_FLAGS, 0, {ez, edc, ec}, 1'b0);
            xfer(1'b0, fa(f), 0, ef, 1'b0);
        end
        // Operand reads of the port take the pins, not the latch
        pin = r2[19:16];
        port_in <= pin;
        xfer(1'b1, fa(7'h06), 32'hFF, 0, 1'b0);
        xfer(1'b1, fa(7'h07), 0, 0, 1'b0);
        xfer(1'b1, instr_exec_pkg::OFS_ACC, 32'hFF, 0, 1'b0);
        ex2({instr_exec_pkg::OPC_LIT_AND, 8'h00}, {instr_exec_pkg::OPC_LIT_AND, 8'h00}, 1'b0);
        xfer(1'b1, instr_exec_pkg::OFS_CTRL, 1, 0, 1'b0);
        ex2({instr_exec_pkg::OPC_REG_AND, 1'b0, 7'h06}, {instr_exec_pkg::OPC_BIT_SET, 3'h0, 7'h06}, 1'b0);
        xfer(1'b1, instr_exec_pkg::OFS_CTRL, 0, 0, 1'b0);
        xfer(1'b0, instr_exec_pkg::OFS_ACC, 0, {4'h0, pin}, 1'b0);
        chk(port_out, pin | 4'h1);
        chk(port_oe_n, 0);
        stop_test;
    end
endmodule : bit_and_logic_instr_exec_tb_top
